// file: hdl/csc_params.svh
// offsets, field positions, reset values and limits of the capture configuration slice
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_STATUS          32'hfffc0008
`define ADDR_IRQ_ENABLE      32'hfffc000c
`define ADDR_IRQ_DISABLE     32'hfffc0010
`define ADDR_IRQ_MASK        32'hfffc0014
`define ADDR_PREVIEW_SIZE    32'hfffc0020
`define ADDR_PREVIEW_DECIM   32'hfffc0024
`define ADDR_PREVIEW_DESC    32'hfffc0028
`define ADDR_CODEC_DMA_BASE  32'hfffc002c
`define ADDR_Y2R_A           32'hfffc0030
`define ADDR_Y2R_B           32'hfffc0034
`define ADDR_R2Y_A           32'hfffc0038
`define ADDR_R2Y_B           32'hfffc003c
`define ADDR_R2Y_C           32'hfffc0040
`define ADDR_CSC_CONTROL     32'hfffc0044

// ----------------------------------------------------------------
// event bit positions (status and mask)
// ----------------------------------------------------------------
`define BIT_CODEC_OVF        5
`define BIT_PREVIEW_OVF      6
`define BIT_PREVIEW_DRAINED  7
`define BIT_CODEC_DRAINED    8
`define BIT_FRAME_OVERRUN    9
`define EVENT_MASK_BITS      32'h000003e0

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define VSIZE_LSB            0
`define HSIZE_LSB            16
`define Y2R_YOFF_BIT         12
`define Y2R_CROFF_BIT        13
`define Y2R_CBOFF_BIT        14
`define R2Y_OFF_BIT          24
`define CTRL_RGB_MODE_BIT    0
`define CTRL_TO_YCC_BIT      1

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define RESET_WORD           32'h00000000
`define RGB_MAX_LINES        10'd480
`define RGB_MAX_PIXELS       11'd640
`define NO_DECIM_LIMIT       8'h10
`define DECIM_STEP           9'h010
`define Y_OFFSET_VALUE       9'd128
`define CR_OFFSET_VALUE      9'd16

`endif

// file: hdl/csc_pkg.sv
// shared types of the capture configuration slice
package csc_pkg;

   typedef struct packed
   {
      logic [7:0] c2;
      logic [7:0] c1;
      logic [7:0] c0;
   } pixel_type;

   typedef enum logic [1:0]
   {
      PREV_IDLE = 2'b01,
      PREV_ACTIVE = 2'b10
   } preview_state_type;

endpackage

// file: hdl/csc_matrix.sv
// 3x3 colour matrix with input and output offsets, saturating to 8 bits
`timescale 1ns/1ns
`default_nettype none

module csc_matrix
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // pixel in, coefficients in 1/512 units
   input wire logic i_valid,
   input wire csc_pkg::pixel_type i_pix,
   input wire logic signed [11:0] i_coef [9],
   input wire logic [8:0] i_in_off [3],
   input wire logic [8:0] i_out_off [3],
   // pixel out
   output logic o_valid,
   output csc_pkg::pixel_type o_pix
);

   logic signed [9:0] diff [3];
   logic [7:0] res [3];

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : row
         logic signed [23:0] acc;
         logic signed [15:0] scaled;
         always_comb
         begin
            diff[g] = $signed({2'b00, i_pix[g*8 +: 8]}) - $signed({1'b0, i_in_off[g]});
         end
         always_comb
         begin
            acc = 24'(i_coef[g*3] * diff[0]) + 24'(i_coef[g*3+1] * diff[1]) + 24'(i_coef[g*3+2] * diff[2]);
            scaled = 16'(acc >>> 9) + $signed({7'b0, i_out_off[g]});
            if (scaled < 0)
            begin
               res[g] = 8'h00;
            end
            else if (scaled > 16'sd255)
            begin
               res[g] = 8'hff;
            end
            else
            begin
               res[g] = scaled[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_valid <= 1'b0;
         o_pix <= '0;
      end
      else
      begin
         o_valid <= i_valid;
         o_pix <= {res[2], res[1], res[0]};
      end
   end

endmodule
`default_nettype wire

// file: hdl/camera_preview_csc_config.sv
// capture unit configuration slice: apb registers, event flags, colour conversion and preview framing
//
// Behaviour
// - mask readback shows codec and preview overflow enables as 1, disabled as 0.
// - mask readback shows preview and codec drained enables as 1, disabled as 0.
// - mask readback shows frame overrun enable as 1, disabled as 0.
// - preview line count is vertical field plus one, capped at 480 in rgb mode.
// - preview pixels per line is horizontal field plus one, capped at 640 in rgb.
// - software writes queue start; reads return the buffer pointer now in use.
// - descriptor address forced to word alignment, low two bits ignored.
// - codec dma base holds the full 32-bit buffer start address.
// - yuv-to-rgb c0..c3 unsigned, one byte each, step 1/128.
// - yuv-to-rgb c4 unsigned nine bits, step 1/128, bit 8 msb.
// - luminance offset bit set applies offset 128, clear applies none.
// - red chroma offset bit set applies offset 16, clear applies none.
// - first rgb-to-yuv set: c0 1/256, c1 1/128, c2 1/512 steps.
// - second rgb-to-yuv set: c3 1/128, c4 1/256, c5 1/512 steps.
// - third rgb-to-yuv set: c6 1/512, c7 1/256, c8 1/128 steps.
// - each rgb-to-yuv set has an offset bit at 24; 0 adds nothing.
// - overflow flagged when a sample arrives while its fifo is full.
// - vsync during fifo flush flags frame overrun and skips the frame.
`include "csc_params.svh"
`timescale 1ns/1ns
`default_nettype none

module camera_preview_csc_config
#(
   parameter logic [8:0] CB_OFFSET = 9'd128,
   parameter logic [8:0] COMPONENT_OFFSET = 9'd16
)
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // fifo and frame events
   input wire logic i_codec_sample_write,
   input wire logic i_codec_fifo_full,
   input wire logic i_preview_sample_write,
   input wire logic i_preview_fifo_full,
   input wire logic i_preview_fifo_drained,
   input wire logic i_codec_fifo_drained,
   input wire logic i_vsync,
   input wire logic i_fifo_flushing,
   // preview dma pointer
   input wire logic i_descriptor_advance,
   input wire logic [31:0] i_descriptor_next,
   // pixels in
   input wire logic i_frame_start,
   input wire logic i_pix_valid,
   input wire csc_pkg::pixel_type i_pix,
   // configuration out
   output logic [31:0] o_interrupt_mask,
   output logic [31:0] o_preview_descriptor_start,
   output logic [31:0] o_codec_dma_base,
   output logic o_frame_skip,
   // preview pixels out
   output logic o_prev_valid,
   output csc_pkg::pixel_type o_prev_pix,
   output logic o_prev_frame_done
);

   initial
   begin
      if (CB_OFFSET > 9'd255 || COMPONENT_OFFSET > 9'd255)
      begin
         $error("offset parameters must fit in 8 bits");
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0] status;
   logic [31:0] preview_image_size;
   logic [7:0] decimation_factor;
   logic [31:0] preview_descriptor_pointer;
   logic [31:0] codec_dma_base;
   logic [31:0] yuv_to_rgb_coeffs_a;
   logic [31:0] yuv_to_rgb_coeffs_b;
   logic [31:0] rgb_to_yuv_coeffs_a;
   logic [31:0] rgb_to_yuv_coeffs_b;
   logic [31:0] rgb_to_yuv_coeffs_c;
   logic [1:0] csc_control;

   logic setup;
   logic wr_en;
   logic rd_done;
   logic mapped;
   logic [31:0] next_rdata;
   logic [31:0] event_set;

   assign setup = i_psel && !i_penable;
   assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
   assign rd_done = i_psel && i_penable && o_pready && !i_pwrite;

   // ----------------------------------------------------------------
   // apb handshake: data is prepared in the setup cycle so the access
   // phase always completes in its first cycle with registered outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      mapped = 1'b1;
      next_rdata = 32'h00000000;
      case (i_paddr)
         `ADDR_STATUS: next_rdata = status;
         `ADDR_IRQ_ENABLE: next_rdata = 32'h00000000;
         `ADDR_IRQ_DISABLE: next_rdata = 32'h00000000;
         `ADDR_IRQ_MASK: next_rdata = o_interrupt_mask;
         `ADDR_PREVIEW_SIZE: next_rdata = preview_image_size;
         `ADDR_PREVIEW_DECIM: next_rdata = {24'h000000, decimation_factor};
         `ADDR_PREVIEW_DESC: next_rdata = preview_descriptor_pointer;
         `ADDR_CODEC_DMA_BASE: next_rdata = codec_dma_base;
         `ADDR_Y2R_A: next_rdata = yuv_to_rgb_coeffs_a;
         `ADDR_Y2R_B: next_rdata = yuv_to_rgb_coeffs_b;
         `ADDR_R2Y_A: next_rdata = rgb_to_yuv_coeffs_a;
         `ADDR_R2Y_B: next_rdata = rgb_to_yuv_coeffs_b;
         `ADDR_R2Y_C: next_rdata = rgb_to_yuv_coeffs_c;
         `ADDR_CSC_CONTROL: next_rdata = {30'h00000000, csc_control};
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= `RESET_WORD;
      end
      else
      begin
         o_pready <= setup;
         if (setup)
         begin
            o_pslverr <= !mapped;
            o_prdata <= i_pwrite ? `RESET_WORD : next_rdata;
         end
         else
         begin
            o_pslverr <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         preview_image_size <= `RESET_WORD;
         decimation_factor <= 8'h00;
         codec_dma_base <= `RESET_WORD;
         yuv_to_rgb_coeffs_a <= `RESET_WORD;
         yuv_to_rgb_coeffs_b <= `RESET_WORD;
         rgb_to_yuv_coeffs_a <= `RESET_WORD;
         rgb_to_yuv_coeffs_b <= `RESET_WORD;
         rgb_to_yuv_coeffs_c <= `RESET_WORD;
         csc_control <= 2'b00;
      end
      else if (wr_en)
      begin
         case (i_paddr)
            `ADDR_PREVIEW_SIZE: preview_image_size <= i_pwdata & 32'h3fff03ff;
            `ADDR_PREVIEW_DECIM: decimation_factor <= i_pwdata[7:0];
            `ADDR_CODEC_DMA_BASE: codec_dma_base <= i_pwdata;
            `ADDR_Y2R_A: yuv_to_rgb_coeffs_a <= i_pwdata;
            `ADDR_Y2R_B: yuv_to_rgb_coeffs_b <= i_pwdata & 32'h000071ff;
            `ADDR_R2Y_A: rgb_to_yuv_coeffs_a <= i_pwdata & 32'h01ffffff;
            `ADDR_R2Y_B: rgb_to_yuv_coeffs_b <= i_pwdata & 32'h01ffffff;
            `ADDR_R2Y_C: rgb_to_yuv_coeffs_c <= i_pwdata & 32'h01ffffff;
            `ADDR_CSC_CONTROL: csc_control <= i_pwdata[1:0];
            default: csc_control <= csc_control;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_codec_dma_base <= `RESET_WORD;
      end
      else
      begin
         o_codec_dma_base <= codec_dma_base;
      end
   end

   // ----------------------------------------------------------------
   // descriptor pointer: a software write restarts the queue, the dma
   // advance follows it; software wins if both land together
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         preview_descriptor_pointer <= `RESET_WORD;
         o_preview_descriptor_start <= `RESET_WORD;
      end
      else if (wr_en && i_paddr == `ADDR_PREVIEW_DESC)
      begin
         preview_descriptor_pointer <= {i_pwdata[31:2], 2'b00};
         o_preview_descriptor_start <= {i_pwdata[31:2], 2'b00};
      end
      else if (i_descriptor_advance)
      begin
         preview_descriptor_pointer <= {i_descriptor_next[31:2], 2'b00};
      end
   end

   // ----------------------------------------------------------------
   // interrupt mask: enable writes set, disable writes clear
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_interrupt_mask <= `RESET_WORD;
      end
      else if (wr_en && i_paddr == `ADDR_IRQ_ENABLE)
      begin
         o_interrupt_mask <= o_interrupt_mask | (i_pwdata & `EVENT_MASK_BITS);
      end
      else if (wr_en && i_paddr == `ADDR_IRQ_DISABLE)
      begin
         o_interrupt_mask <= o_interrupt_mask & ~(i_pwdata & `EVENT_MASK_BITS);
      end
   end

   // ----------------------------------------------------------------
   // event flags: sticky, cleared by a status read, a new event wins
   // ----------------------------------------------------------------
   always_comb
   begin
      event_set = 32'h00000000;
      event_set[`BIT_CODEC_OVF] = i_codec_sample_write && i_codec_fifo_full;
      event_set[`BIT_PREVIEW_OVF] = i_preview_sample_write && i_preview_fifo_full;
      event_set[`BIT_PREVIEW_DRAINED] = i_preview_fifo_drained;
      event_set[`BIT_CODEC_DRAINED] = i_codec_fifo_drained;
      event_set[`BIT_FRAME_OVERRUN] = i_vsync && i_fifo_flushing;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         status <= `RESET_WORD;
      end
      else if (rd_done && i_paddr == `ADDR_STATUS)
      begin
         status <= event_set;
      end
      else
      begin
         status <= status | event_set;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_frame_skip <= 1'b0;
      end
      else
      begin
         o_frame_skip <= i_vsync && i_fifo_flushing;
      end
   end

   // ----------------------------------------------------------------
   // colour conversion coefficients, all scaled to 1/512 units
   // ----------------------------------------------------------------
   logic signed [11:0] coef [9];
   logic [8:0] in_off [3];
   logic [8:0] out_off [3];
   logic to_ycc;
   logic mat_valid;
   csc_pkg::pixel_type mat_pix;

   assign to_ycc = csc_control[`CTRL_TO_YCC_BIT];

   always_comb
   begin
      if (to_ycc)
      begin
         coef[0] = $signed({3'b000, rgb_to_yuv_coeffs_a[7:0], 1'b0});
         coef[1] = $signed({2'b00, rgb_to_yuv_coeffs_a[15:8], 2'b00});
         coef[2] = $signed({4'b0000, rgb_to_yuv_coeffs_a[23:16]});
         coef[3] = $signed({2'b00, rgb_to_yuv_coeffs_b[7:0], 2'b00});
         coef[4] = -$signed({3'b000, rgb_to_yuv_coeffs_b[15:8], 1'b0});
         coef[5] = -$signed({4'b0000, rgb_to_yuv_coeffs_b[23:16]});
         coef[6] = -$signed({4'b0000, rgb_to_yuv_coeffs_c[7:0]});
         coef[7] = -$signed({3'b000, rgb_to_yuv_coeffs_c[15:8], 1'b0});
         coef[8] = $signed({2'b00, rgb_to_yuv_coeffs_c[23:16], 2'b00});
         in_off[0] = 9'd0;
         in_off[1] = 9'd0;
         in_off[2] = 9'd0;
         out_off[0] = rgb_to_yuv_coeffs_a[`R2Y_OFF_BIT] ? COMPONENT_OFFSET : 9'd0;
         out_off[1] = rgb_to_yuv_coeffs_b[`R2Y_OFF_BIT] ? COMPONENT_OFFSET : 9'd0;
         out_off[2] = rgb_to_yuv_coeffs_c[`R2Y_OFF_BIT] ? COMPONENT_OFFSET : 9'd0;
      end
      else
      begin
         // input order y, cr, cb; output order r, g, b
         coef[0] = $signed({2'b00, yuv_to_rgb_coeffs_a[7:0], 2'b00});
         coef[1] = $signed({2'b00, yuv_to_rgb_coeffs_a[15:8], 2'b00});
         coef[2] = 12'sd0;
         coef[3] = $signed({2'b00, yuv_to_rgb_coeffs_a[7:0], 2'b00});
         coef[4] = -$signed({2'b00, yuv_to_rgb_coeffs_a[23:16], 2'b00});
         coef[5] = -$signed({2'b00, yuv_to_rgb_coeffs_a[31:24], 2'b00});
         coef[6] = $signed({2'b00, yuv_to_rgb_coeffs_a[7:0], 2'b00});
         coef[7] = 12'sd0;
         coef[8] = $signed({1'b0, yuv_to_rgb_coeffs_b[8:0], 2'b00});
         in_off[0] = yuv_to_rgb_coeffs_b[`Y2R_YOFF_BIT] ? `Y_OFFSET_VALUE : 9'd0;
         in_off[1] = yuv_to_rgb_coeffs_b[`Y2R_CROFF_BIT] ? `CR_OFFSET_VALUE : 9'd0;
         in_off[2] = yuv_to_rgb_coeffs_b[`Y2R_CBOFF_BIT] ? CB_OFFSET : 9'd0;
         out_off[0] = 9'd0;
         out_off[1] = 9'd0;
         out_off[2] = 9'd0;
      end
   end

   csc_matrix matrix
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_valid(i_pix_valid),
      .i_pix(i_pix),
      .i_coef(coef),
      .i_in_off(in_off),
      .i_out_off(out_off),
      .o_valid(mat_valid),
      .o_pix(mat_pix)
   );

   // ----------------------------------------------------------------
   // preview framing and horizontal decimation
   // ----------------------------------------------------------------
   csc_pkg::preview_state_type state;
   logic [10:0] col;
   logic [9:0] line;
   logic [10:0] pixels_per_line;
   logic [9:0] lines_per_frame;
   logic [8:0] phase;
   logic [8:0] next_phase;
   logic emit;
   logic last_col;
   logic last_line;

   always_comb
   begin
      pixels_per_line = 11'(preview_image_size[`HSIZE_LSB +: 10]) + 11'd1;
      lines_per_frame = preview_image_size[`VSIZE_LSB +: 10] + 10'd1;
      if (csc_control[`CTRL_RGB_MODE_BIT] && pixels_per_line > `RGB_MAX_PIXELS)
      begin
         pixels_per_line = `RGB_MAX_PIXELS;
      end
      if (csc_control[`CTRL_RGB_MODE_BIT] && (lines_per_frame > `RGB_MAX_LINES || lines_per_frame == 10'd0))
      begin
         lines_per_frame = `RGB_MAX_LINES;
      end
   end

   assign last_col = col == pixels_per_line - 11'd1;
   assign last_line = line == lines_per_frame - 10'd1;

   // keeps 16/factor of the pixels; small factors bypass, trading ratio range for no divider
   always_comb
   begin
      next_phase = phase + `DECIM_STEP;
      emit = 1'b1;
      if (decimation_factor > `NO_DECIM_LIMIT)
      begin
         emit = next_phase >= {1'b0, decimation_factor};
         if (emit)
         begin
            next_phase = next_phase - {1'b0, decimation_factor};
         end
      end
      else
      begin
         next_phase = 9'h000;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         state <= csc_pkg::PREV_IDLE;
         col <= 11'd0;
         line <= 10'd0;
         phase <= 9'h000;
         o_prev_valid <= 1'b0;
         o_prev_pix <= '0;
         o_prev_frame_done <= 1'b0;
      end
      else
      begin
         o_prev_valid <= 1'b0;
         o_prev_frame_done <= 1'b0;
         case (state)
            csc_pkg::PREV_IDLE:
            begin
               col <= 11'd0;
               line <= 10'd0;
               phase <= 9'h000;
               if (i_frame_start && !(i_vsync && i_fifo_flushing))
               begin
                  state <= csc_pkg::PREV_ACTIVE;
               end
            end
            csc_pkg::PREV_ACTIVE:
            begin
               if (i_vsync && i_fifo_flushing)
               begin
                  state <= csc_pkg::PREV_IDLE;
               end
               else if (mat_valid)
               begin
                  o_prev_valid <= emit;
                  o_prev_pix <= mat_pix;
                  phase <= last_col ? 9'h000 : next_phase;
                  col <= last_col ? 11'd0 : col + 11'd1;
                  if (last_col)
                  begin
                     line <= line + 10'd1;
                     if (last_line)
                     begin
                        o_prev_frame_done <= 1'b1;
                        state <= csc_pkg::PREV_IDLE;
                     end
                  end
               end
            end
            default: state <= csc_pkg::PREV_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// file: tb/csc_config_asserts.sv
// port assertions for the capture configuration slice
`include "csc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module csc_config_asserts
(
   // clock, reset and apb
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   // events, pixels and configuration
   input wire logic i_vsync,
   input wire logic i_fifo_flushing,
   input wire logic i_pix_valid,
   input wire logic [31:0] o_interrupt_mask,
   input wire logic [31:0] o_codec_dma_base,
   input wire logic o_frame_skip,
   input wire logic o_prev_valid,
   input wire logic o_prev_frame_done
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   logic acc;
   assign acc = i_psel && i_penable && o_pready;
   a_zero_wait: assert property (i_psel && !i_penable |=> o_pready) else $error("no zero wait answer");
   a_mask_set: assert property (acc && i_pwrite && i_paddr == `ADDR_IRQ_ENABLE |=>
      (o_interrupt_mask & $past(i_pwdata) & `EVENT_MASK_BITS) == ($past(i_pwdata) & `EVENT_MASK_BITS))
      else $error("enable bit not shown");
   a_mask_clear: assert property (acc && i_pwrite && i_paddr == `ADDR_IRQ_DISABLE |=>
      (o_interrupt_mask & $past(i_pwdata)) == 32'h0) else $error("disable bit still shown");
   a_mask_hold: assert property (!(acc && i_pwrite && (i_paddr == `ADDR_IRQ_ENABLE ||
      i_paddr == `ADDR_IRQ_DISABLE)) |=> $stable(o_interrupt_mask)) else $error("mask changed alone");
   a_mask_readback: assert property (acc && !i_pwrite && i_paddr == `ADDR_IRQ_MASK |->
      o_prdata == o_interrupt_mask) else $error("mask read differs");
   a_desc_align: assert property (acc && !i_pwrite && i_paddr == `ADDR_PREVIEW_DESC |->
      o_prdata[1:0] == 2'b00) else $error("descriptor not aligned");
   a_codec_base: assert property (acc && i_pwrite && i_paddr == `ADDR_CODEC_DMA_BASE |->
      ##2 o_codec_dma_base == $past(i_pwdata, 2)) else $error("codec base wrong");
   a_skip_follows: assert property (i_vsync && i_fifo_flushing |=> o_frame_skip) else $error("no skip");
   a_skip_cause: assert property (o_frame_skip |-> $past(i_vsync && i_fifo_flushing)) else $error("stray skip");
   a_pix_latency: assert property (o_prev_valid |-> $past(i_pix_valid, 2)) else $error("pixel from nowhere");
   a_done_pixel: assert property (o_prev_frame_done |-> o_prev_valid) else $error("done without pixel");
endmodule
bind camera_preview_csc_config csc_config_asserts chk (.*);
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the capture configuration slice
`include "csc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, adv = 1'b0, fs = 1'b0, pv = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, nxt = 32'h0, prdata, ds, m = 32'h0, seed = 32'd67190;
   logic [7:0] ev = 8'h00;
   csc_pkg::pixel_type pix = 24'h0, ppix;
   logic pready, pslverr, skip, pvo, done;
   logic [32:0] re;
   logic [24:0] pe;
   logic [32:0] rq[$];
   logic [24:0] pq[$];
   int errors = 0, checks = 0, cyc = 0, i;
   logic [31:0] ra[9] = '{`ADDR_PREVIEW_SIZE, `ADDR_PREVIEW_DECIM, `ADDR_PREVIEW_DESC, `ADDR_CODEC_DMA_BASE,
      `ADDR_Y2R_A, `ADDR_Y2R_B, `ADDR_R2Y_A, `ADDR_R2Y_B, `ADDR_R2Y_C};
   logic [31:0] rm[9] = '{32'h3fff03ff, 32'h000000ff, 32'hfffffffc, 32'hffffffff, 32'hffffffff,
      32'h000071ff, 32'h01ffffff, 32'h01ffffff, 32'h01ffffff};
   camera_preview_csc_config dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_codec_sample_write(ev[0]), .i_codec_fifo_full(ev[1]),
      .i_preview_sample_write(ev[2]), .i_preview_fifo_full(ev[3]), .i_preview_fifo_drained(ev[4]),
      .i_codec_fifo_drained(ev[5]), .i_vsync(ev[6]), .i_fifo_flushing(ev[7]), .i_descriptor_advance(adv),
      .i_descriptor_next(nxt), .i_frame_start(fs), .i_pix_valid(pv), .i_pix(pix), .o_interrupt_mask(),
      .o_preview_descriptor_start(ds), .o_codec_dma_base(), .o_frame_skip(skip), .o_prev_valid(pvo),
      .o_prev_pix(ppix), .o_prev_frame_done(done));
   initial forever #50 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task report_and_stop;
      if (rq.size() != 0 || pq.size() != 0)
      begin
         errors++;
         $display("Error at %0t: %0d notes left", $time, rq.size() + pq.size());
      end
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // bus master: hold the request until pready is sampled high
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
         rq.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 33'h0);
   endtask
   task rd(input logic [31:0] a, input logic [32:0] e);
      xfer(1'b0, a, 32'h0, e);
   endtask
   // watchers: compare each answer with the oldest note
   always @(posedge clk)
   begin
      cyc++;
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         re = rq.pop_front();
         checks++;
         if ({pslverr, prdata} !== re)
         begin
            errors++;
            $display("Error at %0t: read %h expected %h", $time, {pslverr, prdata}, re);
         end
      end
      if (pvo === 1'b1)
      begin
         pe = pq.pop_front();
         checks++;
         if ({done, ppix} !== pe)
         begin
            errors++;
            $display("Error at %0t: pixel %h expected %h", $time, {done, ppix}, pe);
         end
      end
      if (cyc == 3000)
      begin
         errors++;
         $display("Error at %0t: timeout", $time);
         report_and_stop();
      end
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(`ADDR_IRQ_MASK, 33'h0);
      for (i = 5; i < 10; i++)
      begin
         m = m | (32'h1 << i);
         wr(`ADDR_IRQ_ENABLE, 32'h1 << i);
         rd(`ADDR_IRQ_MASK, {1'b0, m});
      end
      wr(`ADDR_IRQ_MASK, 32'h0);
      for (i = 9; i > 4; i--)
      begin
         m = m & ~(32'h1 << i);
         wr(`ADDR_IRQ_DISABLE, 32'h1 << i);
         rd(`ADDR_IRQ_MASK, {1'b0, m});
      end
      for (i = 0; i < 9; i++)
      begin
         seed = lfsr(seed);
         if (i == 2)
            m = seed & 32'hfffffffc;
         wr(ra[i], seed);
         rd(ra[i], {1'b0, seed & rm[i]});
      end
      @(posedge clk);
      adv <= 1'b1;
      nxt <= ~seed;
      @(posedge clk);
      adv <= 1'b0;
      rd(`ADDR_PREVIEW_DESC, {1'b0, ~seed & 32'hfffffffc});
      checks++;
      if (ds !== m)
      begin
         errors++;
         $display("Error at %0t: queue start %h expected %h", $time, ds, m);
      end
      rd(32'hfffc0048, {1'b1, 32'h0});
      @(posedge clk);
      ev <= 8'hff;
      @(posedge clk);
      ev <= 8'h00;
      rd(`ADDR_STATUS, {1'b0, `EVENT_MASK_BITS});
      rd(`ADDR_STATUS, 33'h0);
      // unit gain on luma, luma offset on, one line of two pixels
      wr(`ADDR_Y2R_A, 32'h00000080);
      wr(`ADDR_Y2R_B, 32'h00001000);
      wr(`ADDR_PREVIEW_SIZE, 32'h00010000);
      wr(`ADDR_PREVIEW_DECIM, 32'h00000010);
      wr(`ADDR_CSC_CONTROL, 32'h0);
      // second pass: green to luma, blue offset, half decimation drops the first pixel
      for (i = 0; i < 2; i++)
      begin
         if (i == 1)
         begin
            wr(`ADDR_R2Y_A, 32'h00008000);
            wr(`ADDR_R2Y_B, 32'h0);
            wr(`ADDR_R2Y_C, 32'h01000000);
            wr(`ADDR_PREVIEW_DECIM, 32'h00000020);
            wr(`ADDR_CSC_CONTROL, 32'h3);
         end
         @(posedge clk);
         fs <= 1'b1;
         seed = lfsr(seed) | 32'h80;
         @(posedge clk);
         fs <= 1'b0;
         pv <= 1'b1;
         pix <= {3{seed[7:0]}};
         if (i == 0)
            pq.push_back({1'b0, {3{seed[7:0] - 8'h80}}});
         @(posedge clk);
         pix <= {3{seed[15:8] & 8'h7f}};
         pq.push_back(i ? {9'h110, 8'h00, seed[15:8] & 8'h7f} : 25'h1000000);
         @(posedge clk);
         pv <= 1'b0;
         repeat (3) @(posedge clk);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
